// File: core/pca_pkg.sv
// constants, indices and state type of the pci arbiter with strap setup
// assumes a single clock domain and active-low pci request/grant pins
package pca_pkg;
	// ****************************************
	// requester slots
	// ****************************************
	localparam int unsigned PCA_NUM_REQ = 6;
	localparam logic [2:0] PCA_IDX_ZERO = 3'h0;
	localparam logic [2:0] PCA_IDX_TWO = 3'h1;
	localparam logic [2:0] PCA_IDX_THREE = 3'h2;
	localparam logic [2:0] PCA_IDX_FOUR = 3'h3;
	localparam logic [2:0] PCA_IDX_HOST = 3'h4;
	localparam logic [2:0] PCA_IDX_BRIDGE = 3'h5;
	localparam logic [2:0] PCA_IDX_RESET = 3'h5;
	// ****************************************
	// strap levels and pin reset values
	// ****************************************
	localparam logic PCA_STRAP_GROUNDED = 1'h0;
	localparam logic PCA_FAMILY_A_LEVEL = 1'h1;
	localparam logic PCA_PIN_IDLE = 1'h1;
	localparam logic PCA_OE_OFF = 1'h1;
	localparam logic [5:0] PCA_GRANT_NONE = 6'h3f;
	localparam logic [5:0] PCA_ONE_HOT = 6'h01;
	// ****************************************
	// control states
	// ****************************************
	typedef enum logic [1:0]
	{
		PCA_ST_WAIT_PG = 2'b00,
		PCA_ST_ARBITER = 2'b01,
		PCA_ST_EXTERNAL = 2'b10
	} pca_state_type;
endpackage

// File: core/pca_rr_pick.sv
// rotating-priority picker: first active request after the last owner
// assumes requests are active high and last_in is below PCA_NUM_REQ
`timescale 1ns/10ps
module pca_rr_pick
(
	// requests and last owner
	input wire logic [5:0] req_in,
	input wire logic [2:0] last_in,
	// choice
	output logic found_out,
	output logic [2:0] pick_out
);
	import pca_pkg::*;

	function automatic logic [2:0] wrap_add(input logic [2:0] base,
		input logic [2:0] step);
		logic [3:0] sum;
		sum = {1'b0, base} + {1'b0, step};
		if (sum >= 4'(PCA_NUM_REQ))
		begin
			sum = sum - 4'(PCA_NUM_REQ);
		end
		return sum[2:0];
	endfunction

	logic [2:0] cand [1:6];

	genvar k;
	generate
		for (k = 1; k <= 6; k++)
		begin : g_cand
			assign cand[k] = wrap_add(last_in, 3'(k));
		end
	endgenerate

	// lowest step after the last owner wins
	always_comb
	begin
		found_out = 1'b0;
		pick_out = last_in;
		for (int i = 6; i >= 1; i--)
		begin
			if (req_in[cand[i]])
			begin
				found_out = 1'b1;
				pick_out = cand[i];
			end
		end
	end
endmodule

// File: core/pca_arbiter.sv
// pci request/grant arbiter with power-good strap setup and flush handshake
// assumes pins synchronous to clk_in; pad logic resolves two-way pins
`timescale 1ns/10ps
module pca_arbiter
(
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic power_good_in,
	// strap pins with their later grant function
	input wire logic fifth_master_strap_in,
	output logic grant_out_three_out,
	output logic grant_out_three_oe_n_out,
	input wire logic arb_disable_strap_in,
	output logic grant_out_two_out,
	output logic grant_out_two_oe_n_out,
	input wire logic cpu_family_strap_in,
	output logic host_grant_out,
	output logic host_grant_oe_n_out,
	// request inputs, active low
	input wire logic request_in_two_in,
	input wire logic request_in_three_in,
	input wire logic request_in_four_in,
	input wire logic host_request_in,
	// shared pins: grant zero or bridge request, request zero or grant
	output logic bridge_request_out,
	input wire logic bridge_grant_in,
	// shared pin six: grant four or flush request
	output logic grant_out_four_out,
	// internal bridge and flush user side
	input wire logic bridge_need_bus_in,
	output logic bridge_owns_bus_out,
	input wire logic flush_need_in,
	output logic flush_done_out,
	// captured setup
	output logic straps_valid_out,
	output logic arbiter_enabled_out,
	output logic fifth_master_out,
	output logic cpu_family_a_out
);
	import pca_pkg::*;

	pca_state_type state_ff;
	pca_state_type nxt_state;
	logic pg_ff;
	logic disabled_ff;
	logic fifth_ff;
	logic family_ff;
	logic [5:0] grant_n_ff;
	logic [5:0] nxt_grant_n;
	logic [2:0] last_ff;
	logic [2:0] nxt_last;
	logic flush_req_n_ff;
	logic nxt_flush_req_n;
	logic flush_done_ff;
	logic nxt_flush_done;
	logic pin_zero_ff;
	logic pin_six_ff;
	logic bridge_owns_ff;
	logic oe_n_ff;
	logic valid_ff;
	logic enabled_ff;
	logic [5:0] req_act;
	logic found;
	logic [2:0] pick;
	logic pg_rise;
	logic fifth_active;
	logic flush_active;

	// ****************************************
	// strap capture
	// ****************************************
	assign pg_rise = power_good_in & ~pg_ff;

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			pg_ff <= 1'b0;
		else
			pg_ff <= power_good_in;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			disabled_ff <= 1'b0;
			fifth_ff <= 1'b0;
			family_ff <= 1'b0;
		end
		else if (state_ff == PCA_ST_WAIT_PG && pg_rise)
		begin
			disabled_ff <= arb_disable_strap_in == PCA_STRAP_GROUNDED;
			fifth_ff <= fifth_master_strap_in == PCA_STRAP_GROUNDED;
			family_ff <= cpu_family_strap_in == PCA_FAMILY_A_LEVEL;
		end
	end

	// disable overrides the fifth-master strap
	assign fifth_active = state_ff == PCA_ST_ARBITER && fifth_ff;
	assign flush_active = state_ff != PCA_ST_WAIT_PG && !fifth_active;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			PCA_ST_WAIT_PG:
				if (pg_rise)
				begin
					if (arb_disable_strap_in == PCA_STRAP_GROUNDED)
						nxt_state = PCA_ST_EXTERNAL;
					else
						nxt_state = PCA_ST_ARBITER;
				end
			default:
				nxt_state = state_ff;
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			state_ff <= PCA_ST_WAIT_PG;
		else
			state_ff <= nxt_state;
	end

	// ****************************************
	// arbitration
	// ****************************************
	assign req_act[PCA_IDX_ZERO] = ~bridge_grant_in;
	assign req_act[PCA_IDX_TWO] = ~request_in_two_in;
	assign req_act[PCA_IDX_THREE] = ~request_in_three_in;
	assign req_act[PCA_IDX_FOUR] = ~request_in_four_in & fifth_active;
	assign req_act[PCA_IDX_HOST] = ~host_request_in;
	assign req_act[PCA_IDX_BRIDGE] = bridge_need_bus_in;

	pca_rr_pick u_pick
	(
		.req_in(req_act),
		.last_in(last_ff),
		.found_out(found),
		.pick_out(pick)
	);

	// grant held while its request stays; one idle cycle between owners
	always_comb
	begin
		nxt_grant_n = PCA_GRANT_NONE;
		nxt_last = last_ff;
		if (state_ff == PCA_ST_ARBITER)
		begin
			if (grant_n_ff != PCA_GRANT_NONE)
			begin
				if (req_act[last_ff])
					nxt_grant_n = grant_n_ff;
			end
			else if (found)
			begin
				nxt_grant_n = ~(PCA_ONE_HOT << pick);
				nxt_last = pick;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			grant_n_ff <= PCA_GRANT_NONE;
			last_ff <= PCA_IDX_RESET;
		end
		else
		begin
			grant_n_ff <= nxt_grant_n;
			last_ff <= nxt_last;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			oe_n_ff <= PCA_OE_OFF;
		else
			oe_n_ff <= nxt_state != PCA_ST_ARBITER;
	end

	// registered copies of the mode for the status outputs
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			valid_ff <= 1'b0;
			enabled_ff <= 1'b0;
		end
		else
		begin
			valid_ff <= nxt_state != PCA_ST_WAIT_PG;
			enabled_ff <= nxt_state == PCA_ST_ARBITER;
		end
	end

	// ****************************************
	// flush handshake
	// ****************************************
	always_comb
	begin
		nxt_flush_req_n = PCA_PIN_IDLE;
		nxt_flush_done = 1'b0;
		if (flush_active)
		begin
			nxt_flush_req_n = flush_req_n_ff;
			if (!flush_req_n_ff && !request_in_four_in)
			begin
				nxt_flush_req_n = PCA_PIN_IDLE;
				nxt_flush_done = 1'b1;
			end
			else if (flush_req_n_ff && flush_need_in && request_in_four_in)
				nxt_flush_req_n = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			flush_req_n_ff <= PCA_PIN_IDLE;
			flush_done_ff <= 1'b0;
		end
		else
		begin
			flush_req_n_ff <= nxt_flush_req_n;
			flush_done_ff <= nxt_flush_done;
		end
	end

	// ****************************************
	// shared pins
	// ****************************************
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			pin_six_ff <= PCA_PIN_IDLE;
			pin_zero_ff <= PCA_PIN_IDLE;
			bridge_owns_ff <= 1'b0;
		end
		else
		begin
			if (fifth_active)
				pin_six_ff <= nxt_grant_n[PCA_IDX_FOUR];
			else
				pin_six_ff <= nxt_flush_req_n;
			if (state_ff == PCA_ST_EXTERNAL)
			begin
				pin_zero_ff <= ~bridge_need_bus_in;
				bridge_owns_ff <= bridge_need_bus_in && !pin_zero_ff
					&& !bridge_grant_in;
			end
			else
			begin
				pin_zero_ff <= nxt_grant_n[PCA_IDX_ZERO];
				bridge_owns_ff <= !nxt_grant_n[PCA_IDX_BRIDGE];
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign grant_out_three_out = grant_n_ff[PCA_IDX_THREE];
	assign grant_out_three_oe_n_out = oe_n_ff;
	assign grant_out_two_out = grant_n_ff[PCA_IDX_TWO];
	assign grant_out_two_oe_n_out = oe_n_ff;
	assign host_grant_out = grant_n_ff[PCA_IDX_HOST];
	assign host_grant_oe_n_out = oe_n_ff;
	assign bridge_request_out = pin_zero_ff;
	assign grant_out_four_out = pin_six_ff;
	assign bridge_owns_bus_out = bridge_owns_ff;
	assign flush_done_out = flush_done_ff;
	assign straps_valid_out = valid_ff;
	assign arbiter_enabled_out = enabled_ff;
	assign fifth_master_out = fifth_ff;
	assign cpu_family_a_out = family_ff;

	// ****************************************
	// checks
	// ****************************************
	a_one_grant_only:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$onehot0(~grant_n_ff))
	else $error("more than one grant active");

	a_grant_needs_request:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$fell(grant_out_three_out) |-> $past(!request_in_three_in))
	else $error("grant three without request");

	a_grant_drops_release:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(!host_grant_out && host_request_in) |=> host_grant_out)
	else $error("host grant held after request release");

	a_disable_strap_mode:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(state_ff == PCA_ST_WAIT_PG && pg_rise && !arb_disable_strap_in)
		|=> !arbiter_enabled_out && disabled_ff && host_grant_oe_n_out)
	else $error("grounded disable strap did not disable arbiter");

	a_flush_pin_follow:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(state_ff == PCA_ST_EXTERNAL) |-> grant_out_four_out == flush_req_n_ff)
	else $error("pin six not flush request while disabled");

	a_flush_ack_release:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(flush_active && !flush_req_n_ff && !request_in_four_in
		&& state_ff == $past(state_ff))
		|=> grant_out_four_out && flush_done_out ##1 !flush_done_out)
	else $error("flush request not released on acknowledge");

	a_family_capture:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(state_ff == PCA_ST_WAIT_PG && pg_rise)
		|=> cpu_family_a_out == $past(cpu_family_strap_in) && straps_valid_out)
	else $error("cpu family strap not captured");

	a_bridge_request_follow:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(state_ff == PCA_ST_EXTERNAL && $past(state_ff) == PCA_ST_EXTERNAL)
		|-> bridge_request_out == $past(!bridge_need_bus_in))
	else $error("bridge request not following need");

	a_no_drive_before:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(state_ff == PCA_ST_WAIT_PG) |-> grant_out_two_oe_n_out
		&& grant_out_three_oe_n_out && grant_n_ff == PCA_GRANT_NONE)
	else $error("strap pin driven before straps sampled");

	a_fifth_grant_pin:
	assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(fifth_active && $past(fifth_active))
		|-> grant_out_four_out == grant_n_ff[PCA_IDX_FOUR])
	else $error("pin six not grant four in fifth-master mode");
endmodule

// File: tb/pca_partner.sv
// far side: outside masters, host bridge, flush agent, outer arbiter
// assumes active-low pins that change on rising clk_in edges
`timescale 1ns/10ps
module pca_partner
#(
	parameter int ACK_CYCLES = 2
)
(
	// clock and mode
	input wire logic clk_in,
	input wire logic disabled_in,
	input wire logic fifth_in,
	// wishes: bit0 pin25, 1 two, 2 three, 3 four, 4 host
	input wire logic [4:0] want_in,
	// device outputs
	input wire logic pin6_in,
	input wire logic pin26_in,
	// device inputs
	output logic req_zero_out,
	output logic req_two_out,
	output logic req_three_out,
	output logic req_four_out,
	output logic host_req_out
);
	logic [3:0] ack_wait_ff = 4'h0;
	logic ack_ff = 1'h1;
	logic ext_grant_ff = 1'h1;
	assign req_two_out = ~want_in[1];
	assign req_three_out = ~want_in[2];
	assign host_req_out = ~want_in[4];
	assign req_zero_out = disabled_in ? ext_grant_ff : ~want_in[0];
	assign req_four_out = (disabled_in | fifth_in) ? ack_ff : ~want_in[3];
	// flush agent acks late, holds until request drops
	always_ff @(posedge clk_in)
	begin
		if (pin6_in)
		begin
			ack_wait_ff <= 4'h0;
			ack_ff <= 1'h1;
		end
		else if (ack_wait_ff == 4'(ACK_CYCLES))
			ack_ff <= 1'h0;
		else
			ack_wait_ff <= ack_wait_ff + 4'h1;
	end
	// outer arbiter answers the bridge one cycle later
	always_ff @(posedge clk_in)
		ext_grant_ff <= pin26_in;
endmodule

// File: tb/pca_arbiter_tb.sv
// self-checking bench for the strapped pci arbiter
// assumes pca_partner models every party on the far side
`timescale 1ns/10ps
module pca_arbiter_tb;
	logic clk_in = 1'h0;
	logic reset_n_in = 1'h0;
	logic power_good_in = 1'h0;
	logic fifth_strap = 1'h1;
	logic dis_strap = 1'h1;
	logic fam_strap = 1'h1;
	logic bridge_need = 1'h0;
	logic flush_need = 1'h0;
	logic [4:0] want = 5'h00;
	logic g3, g3_oe_n, g2, g2_oe_n, hg, hg_oe_n;
	logic r0, r2, r3, r4, hr, pin26, pin6, owns, done;
	logic valid, enabled, fifth, fam_a;
	int errors = 0;
	int comparisons = 0;
	always #12.5 clk_in = ~clk_in;
	pca_arbiter dut
	(
		.clk_in(clk_in), .reset_n_in(reset_n_in),
		.power_good_in(power_good_in),
		.fifth_master_strap_in(fifth_strap),
		.grant_out_three_out(g3), .grant_out_three_oe_n_out(g3_oe_n),
		.arb_disable_strap_in(dis_strap),
		.grant_out_two_out(g2), .grant_out_two_oe_n_out(g2_oe_n),
		.cpu_family_strap_in(fam_strap),
		.host_grant_out(hg), .host_grant_oe_n_out(hg_oe_n),
		.request_in_two_in(r2), .request_in_three_in(r3),
		.request_in_four_in(r4), .host_request_in(hr),
		.bridge_request_out(pin26), .bridge_grant_in(r0),
		.grant_out_four_out(pin6),
		.bridge_need_bus_in(bridge_need), .bridge_owns_bus_out(owns),
		.flush_need_in(flush_need), .flush_done_out(done),
		.straps_valid_out(valid), .arbiter_enabled_out(enabled),
		.fifth_master_out(fifth), .cpu_family_a_out(fam_a)
	);
	pca_partner partner
	(
		.clk_in(clk_in), .disabled_in(~dis_strap),
		.fifth_in(fifth_strap), .want_in(want),
		.pin6_in(pin6), .pin26_in(pin26),
		.req_zero_out(r0), .req_two_out(r2), .req_three_out(r3),
		.req_four_out(r4), .host_req_out(hr)
	);
	// ****
	// helpers
	// ****
	task check(input string name, input logic seen, input logic exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", name, exp, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask
	task start(input logic dis, input logic fif, input logic fam);
		reset_n_in = 1'h0;
		power_good_in = 1'h0;
		dis_strap = dis;
		fifth_strap = fif;
		fam_strap = fam;
		tick(16);
		check("valid_in_reset", valid, 1'h0);
		check("oe_in_reset", g2_oe_n, 1'h1);
		reset_n_in = 1'h1;
		tick(2);
		power_good_in = 1'h1;
		tick(3);
		check("valid", valid, 1'h1);
		check("enabled", enabled, dis);
		check("family_a", fam_a, fam);
	endtask
	task do_flush;
		int i;
		i = 0;
		flush_need = 1'h1;
		tick(2);
		check("flush_req", pin6, 1'h0);
		while (done !== 1'h1 && i < 20)
		begin
			tick(1);
			i++;
		end
		check("flush_done", done, 1'h1);
		check("flush_req_off", pin6, 1'h1);
		tick(1);
		check("done_pulse", done, 1'h0);
		check("no_reissue", pin6, 1'h1);
		flush_need = 1'h0;
		tick(3);
	endtask
	// ****
	// scenarios
	// ****
	task test_fifth_arb;
		start(1'h1, 1'h0, 1'h1);
		check("fifth", fifth, 1'h1);
		check("g3_oe", g3_oe_n, 1'h0);
		check("hg_oe", hg_oe_n, 1'h0);
		want = 5'b00100;
		tick(2);
		check("g3", g3, 1'h0);
		want = 5'b00000;
		tick(2);
		check("g3_off", g3, 1'h1);
		want = 5'b01010;
		tick(2);
		check("g4", pin6, 1'h0);
		check("g2_wait", g2, 1'h1);
		want = 5'b00010;
		tick(2);
		check("g4_off", pin6, 1'h1);
		tick(1);
		check("g2", g2, 1'h0);
		want = 5'b10000;
		tick(2);
		check("g2_off", g2, 1'h1);
		tick(1);
		check("host", hg, 1'h0);
		want = 5'b00000;
		bridge_need = 1'h1;
		tick(5);
		check("own_slot", owns, 1'h1);
		check("g0_idle", pin26, 1'h1);
		bridge_need = 1'h0;
		tick(3);
	endtask
	task test_flush_mode;
		start(1'h1, 1'h1, 1'h0);
		check("fifth_off", fifth, 1'h0);
		do_flush();
	endtask
	task test_disabled;
		int i;
		i = 0;
		start(1'h0, 1'h0, 1'h1);
		check("g3_oe_off", g3_oe_n, 1'h1);
		check("hg_oe_off", hg_oe_n, 1'h1);
		do_flush();
		bridge_need = 1'h1;
		tick(2);
		check("bridge_req", pin26, 1'h0);
		while (owns !== 1'h1 && i < 10)
		begin
			tick(1);
			i++;
		end
		check("bridge_owns", owns, 1'h1);
		bridge_need = 1'h0;
		tick(3);
		check("bridge_rel", pin26, 1'h1);
		check("owns_off", owns, 1'h0);
	endtask
	task stop_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#(25 * 3000);
		errors++;
		stop_test();
	end
	initial
	begin
		test_fifth_arb();
		test_flush_mode();
		test_disabled();
		stop_test();
	end
endmodule
